//--- inc/gtrf_pkg.sv
// Constants and types of the timing report framer.
// Assumes a 50 MHz system clock and a 32-bit register bus.
`default_nettype none
package gtrf_pkg;
    // Clock and report start deadline
    localparam int CLK_HZ     = 50_000_000;
    localparam int START_MS   = 30;
    localparam int START_CYC  = START_MS * (CLK_HZ / 1000);
    // Register byte offsets
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_REQ    = 4'h4;
    localparam logic [3:0] ADDR_ECHO   = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hC;
    // Control fields and reset value
    localparam int         CTRL_PRIM   = 0;
    localparam int         CTRL_SUPP   = 1;
    localparam int         CTRL_UTC    = 2;
    localparam logic [2:0] CTRL_RESET  = 3'h0;
    localparam int         ECHO_MASK_LSB = 8;
    // Packet subcodes and echo command codes
    localparam logic [7:0] SUB_PRIM    = 8'hAB;
    localparam logic [7:0] SUB_SUPP    = 8'hAC;
    localparam logic [7:0] CMD_MASK    = 8'hA5;
    localparam logic [7:0] CMD_SURVEY  = 8'hA6;
    localparam logic [7:0] CMD_CFG     = 8'hA9;
    // Week rollover correction
    localparam logic [15:0] WEEK_ROLL  = 16'h0400;
    localparam logic [9:0]  WEEK_LIMIT = 10'h3FF;
    // Packet lengths in bytes
    localparam logic [4:0] PRIM_LEN    = 5'h11;
    localparam logic [4:0] SUPP_LEN    = 5'h10;
    localparam logic [4:0] ECHO_LEN    = 5'h04;
    // Time-only receiver modes
    localparam logic [7:0] MODE_ONESAT = 8'h01;
    localparam logic [7:0] MODE_HOLD   = 8'h06;
    localparam logic [7:0] MODE_OVDET  = 8'h07;
    // Clock of day limits
    localparam logic [5:0] SEC_LAST    = 6'h3B;
    localparam logic [5:0] SEC_LEAP    = 6'h3C;
    localparam logic [5:0] MIN_LAST    = 6'h3B;
    localparam logic [4:0] HOUR_LAST   = 5'h17;
    // Packet in flight
    typedef enum logic [3:0] {
        PK_IDLE = 4'h1,
        PK_PRIM = 4'h2,
        PK_SUPP = 4'h4,
        PK_ECHO = 4'h8
    } gtrf_pkt_e;
endpackage
`default_nettype wire

//--- core/gtrf_tod.sv
// Clock of day counter stepped by the second tick.
// Assumes tick and load come from logic on the same clock.
`default_nettype none
module gtrf_tod (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       tick_in,
    input  wire logic       load_in,
    input  wire logic [4:0] load_hour_in,
    input  wire logic [5:0] load_min_in,
    input  wire logic [5:0] load_sec_in,
    input  wire logic       leap_in,
    output logic      [4:0] hour_out,
    output logic      [5:0] min_out,
    output logic      [5:0] sec_out
);
    // End of day and leap second detection
    wire at_day_end = (hour_out == gtrf_pkg::HOUR_LAST) && (min_out == gtrf_pkg::MIN_LAST)
                      && (sec_out == gtrf_pkg::SEC_LAST);
    wire at_leap    = (sec_out == gtrf_pkg::SEC_LEAP);
    wire sec_wrap   = (sec_out == gtrf_pkg::SEC_LAST) && !(at_day_end && leap_in);
    wire min_wrap   = (min_out == gtrf_pkg::MIN_LAST);

    // Advance one second per tick, through :60 on a leap insertion
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            hour_out <= 5'h00;
            min_out  <= 6'h00;
            sec_out  <= 6'h00;
        end else if (load_in) begin
            hour_out <= load_hour_in;
            min_out  <= load_min_in;
            sec_out  <= load_sec_in;
        end else if (tick_in) begin
            if (at_leap) begin
                hour_out <= 5'h00;
                min_out  <= 6'h00;
                sec_out  <= 6'h00;
            end else if (sec_wrap) begin
                sec_out <= 6'h00;
                if (min_wrap) begin
                    min_out  <= 6'h00;
                    hour_out <= (hour_out == gtrf_pkg::HOUR_LAST) ? 5'h00 : hour_out + 5'h01;
                end else begin
                    min_out <= min_out + 6'h01;
                end
            end else begin
                sec_out <= sec_out + 6'h01;
            end
        end
    end

    chk_tod_leap: assert property (@(posedge clk_in) disable iff (rst_in)
        (tick_in && !load_in && at_leap) |=> (sec_out == 6'h00 && min_out == 6'h00
        && hour_out == 5'h00))
        else $error("Leap second did not step to midnight");
endmodule
`default_nettype wire

//--- core/gtrf_framer.sv
// Timing report framer: snapshots time at each pulse and streams reports.
// Assumes a byte sink on the same clock and a time engine on the same clock.
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`default_nettype none
// Functional notes
// - With the primary enable set, a primary report goes out every second.
// - Primary report starts within 30 ms of its timing pulse.
// - Host request makes the device send a primary report.
// - Seconds-into-week counts whole seconds since Sunday midnight, satellite time.
// - Week number counts from the week starting January 6, 1980.
// - Broadcast week below 1023 gets 1024 added before reporting.
// - Leap offset N gives UTC equal to satellite time minus N.
// - Offset reads zero until leap information arrives; only satellite scale then.
// - Flag bit 0 is 1 for UTC date and time, 0 for satellite scale.
// - Flag bit 2 is 1 while time is unset.
// - Flag bit 3 is 1 while leap offset is unknown.
// - Time of day wraps at 23:59:59, passing 23:59:60 on leap insertion.
// - Bytes 10-14 hold sec, min, hour, day, month; 15-16 the year.
// - Supplemental report follows each primary report when enabled.
// - Host request makes the device send a supplemental report.
// - During self-survey the reported position is the running average.
// - After survey or in time-only mode, the time-only position is reported; here only a time-only mode selects it, a finished survey gives the fix.
// - Otherwise the previous second's fix is reported.
// - Echo commands are answered by a report of identical structure.
module gtrf_framer #(
    parameter int START_CYCLES = gtrf_pkg::START_CYC
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic [3:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire logic        pps_in,
    input  wire logic [19:0] sow_in,
    input  wire logic [9:0]  week_raw_in,
    input  wire logic [15:0] leap_offset_in,
    input  wire logic        leap_known_in,
    input  wire logic        leap_insert_in,
    input  wire logic        time_set_in,
    input  wire logic        tod_load_in,
    input  wire logic [4:0]  hour_in,
    input  wire logic [5:0]  min_in,
    input  wire logic [5:0]  sec_in,
    input  wire logic [4:0]  day_in,
    input  wire logic [3:0]  month_in,
    input  wire logic [15:0] year_in,
    input  wire logic [7:0]  rx_mode_in,
    input  wire logic        survey_active_in,
    input  wire logic [7:0]  survey_progress_in,
    input  wire logic [95:0] pos_avg_in,
    input  wire logic [95:0] pos_hold_in,
    input  wire logic [95:0] pos_fix_in,
    output logic      [7:0]  tx_data_out,
    output logic             tx_valid_out,
    output logic             tx_first_out,
    output logic             tx_last_out,
    input  wire logic        tx_ready_in
);
    logic [2:0]  ctrl;
    logic [31:0] echo_word;
    logic        prim_pend;
    logic        supp_pend;
    logic        echo_pend;
    logic [2:0]  pps_sync;
    logic        tick_d;
    logic [19:0] snap_sow;
    logic [15:0] snap_week;
    logic [15:0] snap_off;
    logic [7:0]  snap_flags;
    logic [5:0]  snap_sec;
    logic [5:0]  snap_min;
    logic [4:0]  snap_hour;
    logic [4:0]  snap_day;
    logic [3:0]  snap_month;
    logic [15:0] snap_year;
    logic [7:0]  snap_mode;
    logic [7:0]  snap_prog;
    logic [95:0] snap_pos;
    logic [31:0] echo_snap;
    logic [4:0]  idx;
    logic [4:0]  cur_len;
    logic [31:0] prim_wait;
    gtrf_pkg::gtrf_pkt_e state;
    logic [4:0]  tod_hour;
    logic [5:0]  tod_min;
    logic [5:0]  tod_sec;

    // Pulse edge after the second synchroniser stage
    wire pps_tick = pps_sync[1] && !pps_sync[2];

    // Bus decode
    wire acc      = (avs_read_in || avs_write_in) && !avs_waitrequest_out;
    wire wr_acc   = acc && avs_write_in;
    wire wr_ctrl  = wr_acc && (avs_address_in == gtrf_pkg::ADDR_CTRL);
    wire wr_req   = wr_acc && (avs_address_in == gtrf_pkg::ADDR_REQ);
    wire wr_echo  = wr_acc && (avs_address_in == gtrf_pkg::ADDR_ECHO);
    wire [7:0] cmd_code = avs_writedata_in[31:24];
    wire cmd_ok   = (cmd_code == gtrf_pkg::CMD_MASK) || (cmd_code == gtrf_pkg::CMD_SURVEY)
                    || (cmd_code == gtrf_pkg::CMD_CFG);
    wire echo_go  = wr_echo && cmd_ok;
    wire mask_go  = echo_go && (cmd_code == gtrf_pkg::CMD_MASK);
    wire req_prim = wr_req && avs_writedata_in[0];
    wire req_supp = wr_req && avs_writedata_in[1];

    // Register read mux, unmapped words read zero
    wire [7:0]  live_flags;
    wire [31:0] rd_mux =
        (avs_address_in == gtrf_pkg::ADDR_CTRL)   ? {29'h0, ctrl} :
        (avs_address_in == gtrf_pkg::ADDR_REQ)    ? {29'h0, echo_pend, supp_pend, prim_pend} :
        (avs_address_in == gtrf_pkg::ADDR_ECHO)   ? echo_word :
        (avs_address_in == gtrf_pkg::ADDR_STATUS) ? {20'h0, state, live_flags} : 32'h0;

    // Waitrequest drops for one cycle per request, read data stand with it
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= 32'h0;
        end else begin
            avs_waitrequest_out <= !((avs_read_in || avs_write_in) && avs_waitrequest_out);
            if (avs_read_in && avs_waitrequest_out)
                avs_readdata_out <= rd_mux;
        end
    end

    // Control and echo registers; a mask command also updates the enables
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl      <= gtrf_pkg::CTRL_RESET;
            echo_word <= 32'h0;
        end else begin
            if (wr_ctrl)
                ctrl <= avs_writedata_in[2:0];
            else if (mask_go)
                ctrl[1:0] <= avs_writedata_in[gtrf_pkg::ECHO_MASK_LSB +: 2];
            if (echo_go)
                echo_word <= avs_writedata_in;
        end
    end

    // Pulse synchroniser
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pps_sync <= 3'h0;
            tick_d   <= 1'b0;
        end else begin
            pps_sync <= {pps_sync[1:0], pps_in};
            tick_d   <= pps_tick;
        end
    end

    // Clock of day, leap second only counted in the UTC scale
    wire utc_on = ctrl[gtrf_pkg::CTRL_UTC] && leap_known_in;
    gtrf_tod u_tod (
        .clk_in       (clk_in),
        .rst_in       (rst_in),
        .tick_in      (pps_tick),
        .load_in      (tod_load_in),
        .load_hour_in (hour_in),
        .load_min_in  (min_in),
        .load_sec_in  (sec_in),
        .leap_in      (leap_insert_in && utc_on),
        .hour_out     (tod_hour),
        .min_out      (tod_min),
        .sec_out      (tod_sec)
    );

    // Field conversion ahead of the snapshot
    wire [15:0] week_fix = (week_raw_in < gtrf_pkg::WEEK_LIMIT) ?
                           {6'h00, week_raw_in} + gtrf_pkg::WEEK_ROLL :
                           {6'h00, week_raw_in};
    wire [15:0] off_fix  = leap_known_in ? leap_offset_in : 16'h0000;
    assign live_flags = {4'h0, !leap_known_in, !time_set_in, 1'b0, utc_on};
    wire time_only = (rx_mode_in == gtrf_pkg::MODE_ONESAT) ||
                     (rx_mode_in == gtrf_pkg::MODE_HOLD) || (rx_mode_in == gtrf_pkg::MODE_OVDET);
    wire [95:0] pos_sel = survey_active_in ? pos_avg_in :
                          time_only ? pos_hold_in : pos_fix_in;

    // One snapshot per pulse, taken once the clock of day has stepped
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            snap_sow   <= 20'h0;
            snap_week  <= 16'h0;
            snap_off   <= 16'h0;
            snap_flags <= 8'h0C;
            snap_sec   <= 6'h0;
            snap_min   <= 6'h0;
            snap_hour  <= 5'h0;
            snap_day   <= 5'h0;
            snap_month <= 4'h0;
            snap_year  <= 16'h0;
            snap_mode  <= 8'h0;
            snap_prog  <= 8'h0;
            snap_pos   <= 96'h0;
        end else if (tick_d) begin
            snap_sow   <= sow_in;
            snap_week  <= week_fix;
            snap_off   <= off_fix;
            snap_flags <= live_flags;
            snap_sec   <= tod_sec;
            snap_min   <= tod_min;
            snap_hour  <= tod_hour;
            snap_day   <= day_in;
            snap_month <= month_in;
            snap_year  <= year_in;
            snap_mode  <= rx_mode_in;
            snap_prog  <= survey_progress_in;
            snap_pos   <= pos_sel;
        end
    end

    // Report images, byte 0 in the top bits
    wire [135:0] prim_img = {gtrf_pkg::SUB_PRIM, 12'h0, snap_sow, snap_week, snap_off,
                             snap_flags, 2'h0, snap_sec, 2'h0, snap_min, 3'h0, snap_hour,
                             3'h0, snap_day, 4'h0, snap_month, snap_year};
    wire [127:0] supp_img = {gtrf_pkg::SUB_SUPP, snap_mode, 8'h00, snap_prog, snap_pos};
    wire [7:0] prim_byte = prim_img[8'(gtrf_pkg::PRIM_LEN - 5'h01 - idx) * 8 +: 8];
    wire [7:0] supp_byte = supp_img[7'(gtrf_pkg::SUPP_LEN - 5'h01 - idx) * 8 +: 8];
    wire [7:0] echo_byte = echo_snap[5'(gtrf_pkg::ECHO_LEN - 5'h01 - idx) * 8 +: 8];
    wire [7:0] cur_byte  = (state == gtrf_pkg::PK_PRIM) ? prim_byte :
                           (state == gtrf_pkg::PK_SUPP) ? supp_byte : echo_byte;

    // Start arbitration: primary, then supplemental, then echo
    wire idle      = (state == gtrf_pkg::PK_IDLE);
    wire start_p   = idle && prim_pend;
    wire start_s   = idle && !prim_pend && supp_pend;
    wire start_e   = idle && !prim_pend && !supp_pend && echo_pend;
    wire byte_go   = !idle && (!tx_valid_out || tx_ready_in);
    wire byte_last = (idx == cur_len - 5'h01);

    // Pending flags; a new set wins over the clear at start
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            prim_pend <= 1'b0;
            supp_pend <= 1'b0;
            echo_pend <= 1'b0;
        end else begin
            if ((tick_d && ctrl[gtrf_pkg::CTRL_PRIM]) || req_prim)
                prim_pend <= 1'b1;
            else if (start_p)
                prim_pend <= 1'b0;
            if ((tick_d && ctrl[gtrf_pkg::CTRL_SUPP]) || req_supp)
                supp_pend <= 1'b1;
            else if (start_s)
                supp_pend <= 1'b0;
            if (echo_go)
                echo_pend <= 1'b1;
            else if (start_e)
                echo_pend <= 1'b0;
        end
    end

    // Packet state and byte index
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state     <= gtrf_pkg::PK_IDLE;
            idx       <= 5'h0;
            cur_len   <= 5'h0;
            echo_snap <= 32'h0;
        end else begin
            unique case (state)
                gtrf_pkg::PK_IDLE: begin
                    idx <= 5'h0;
                    if (start_p) begin
                        state   <= gtrf_pkg::PK_PRIM;
                        cur_len <= gtrf_pkg::PRIM_LEN;
                    end else if (start_s) begin
                        state   <= gtrf_pkg::PK_SUPP;
                        cur_len <= gtrf_pkg::SUPP_LEN;
                    end else if (start_e) begin
                        state     <= gtrf_pkg::PK_ECHO;
                        cur_len   <= gtrf_pkg::ECHO_LEN;
                        echo_snap <= echo_word;
                    end
                end
                gtrf_pkg::PK_PRIM, gtrf_pkg::PK_SUPP, gtrf_pkg::PK_ECHO: begin
                    if (byte_go) begin
                        idx <= idx + 5'h01;
                        if (byte_last)
                            state <= gtrf_pkg::PK_IDLE;
                    end
                end
                default: state <= gtrf_pkg::PK_IDLE;
            endcase
        end
    end

    // Byte output stage with back-pressure
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_data_out  <= 8'h0;
            tx_valid_out <= 1'b0;
            tx_first_out <= 1'b0;
            tx_last_out  <= 1'b0;
        end else if (byte_go) begin
            tx_data_out  <= cur_byte;
            tx_valid_out <= 1'b1;
            tx_first_out <= (idx == 5'h0);
            tx_last_out  <= byte_last;
        end else if (tx_ready_in) begin
            tx_valid_out <= 1'b0;
        end
    end

    // Cycles a primary report has waited since its pulse
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in)
            prim_wait <= 32'h0;
        else if (!prim_pend || start_p)
            prim_wait <= 32'h0;
        else
            prim_wait <= prim_wait + 32'h1;
    end

    sequence s_tick_enabled;
        tick_d && ctrl[gtrf_pkg::CTRL_PRIM];
    endsequence
    sequence s_prim_start;
        ##[1:40] (state == gtrf_pkg::PK_PRIM);
    endsequence

    chk_auto_primary: assert property (@(posedge clk_in) disable iff (rst_in)
        s_tick_enabled |=> prim_pend)
        else $error("Enabled pulse did not queue a primary report");
    chk_start_deadline: assert property (@(posedge clk_in) disable iff (rst_in)
        prim_wait < START_CYCLES)
        else $error("Primary report started too late");
    chk_request_prim: assert property (@(posedge clk_in) disable iff (rst_in)
        (req_prim && idle && !tx_valid_out) |-> s_prim_start)
        else $error("Requested primary report never started");
    chk_week_fix: assert property (@(posedge clk_in) disable iff (rst_in)
        (tick_d && week_raw_in < 10'h3FF) |=> (snap_week == {6'h00, $past(week_raw_in)} + 16'h0400))
        else $error("Week rollover not corrected");
    chk_offset_zero: assert property (@(posedge clk_in) disable iff (rst_in)
        (tick_d && !leap_known_in) |=> (snap_off == 16'h0 && !snap_flags[0] && snap_flags[3]))
        else $error("Offset or flags wrong without leap info");
    chk_flag_set: assert property (@(posedge clk_in) disable iff (rst_in)
        tick_d |=> (snap_flags[2] == !$past(time_set_in)))
        else $error("Time-set flag wrong");
    chk_flag_utc: assert property (@(posedge clk_in) disable iff (rst_in)
        tick_d |=> (snap_flags[0] == $past(utc_on) && snap_flags[1] == 1'b0))
        else $error("Scale flag wrong");
    chk_supp_order: assert property (@(posedge clk_in) disable iff (rst_in)
        (state == gtrf_pkg::PK_SUPP && $past(idle)) |-> !$past(prim_pend))
        else $error("Supplemental report overtook a primary report");
    chk_pos_survey: assert property (@(posedge clk_in) disable iff (rst_in)
        (tick_d && survey_active_in) |=> (snap_pos == $past(pos_avg_in)))
        else $error("Survey average position not reported");
    chk_echo_queue: assert property (@(posedge clk_in) disable iff (rst_in)
        echo_go |=> (echo_pend && echo_word[31:24] == $past(cmd_code)))
        else $error("Echo command not queued");
endmodule
`default_nettype wire

//--- tb/gtrf_sink.sv
// Host side byte sink that collects report bytes for the bench.
// Assumes the framer's byte stream on the same clock.
`default_nettype none
module gtrf_sink (
    input  wire logic       clk_in,
    input  wire logic       slow_in,
    input  wire logic [7:0] data_in,
    input  wire logic       valid_in,
    input  wire logic       first_in,
    input  wire logic       last_in,
    output logic            ready_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] rx_q[$];
    int         idx = 0;
    int         pkts = 0;
    logic       is_prim = 1'b0;
    initial ready_out = 1'b0;
    // Take a byte on valid and ready; stall every other cycle when slow
    always @(posedge clk_in) begin
        if (valid_in && ready_out) begin
            idx = first_in ? 0 : idx + 1;
            if (first_in) is_prim = (data_in == gtrf_pkg::SUB_PRIM);
            // Undefined flag bit 1 of the primary report is disregarded
            rx_q.push_back((is_prim && idx == 9) ? (data_in & 8'hFD) : data_in);
            pkts += int'(first_in) + int'(last_in);
        end
        ready_out <= !slow_in || !ready_out;
    end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench: register bus, pulse-driven reports, requests, echoes.
// Assumes the framer package, framer and sink model are compiled first.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_in = 1'b0, rst_in = 1'b1, pps_in = 1'b0, tod_load_in = 1'b0, slow = 1'b0;
    logic        avs_read_in = 1'b0, avs_write_in = 1'b0, leap_known_in = 1'b0;
    logic        leap_insert_in = 1'b0, time_set_in = 1'b0, survey_active_in = 1'b1;
    logic [3:0]  avs_address_in = 4'h0, month_in = 4'h1;
    logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rd_q, d;
    logic [19:0] sow_in = 20'h0;
    logic [9:0]  week_raw_in = 10'h0;
    logic [15:0] leap_offset_in = 16'h0, year_in = 16'h0, rnd = 16'h0012;
    logic [4:0]  hour_in = 5'h17, day_in = 5'h1;
    logic [5:0]  min_in = 6'h3B, sec_in = 6'h3A;
    logic [7:0]  rx_mode_in = 8'h0, survey_progress_in = 8'h0, tx_data_out;
    logic [95:0] pos_avg_in = 96'h0, pos_hold_in = 96'h0, pos_fix_in = 96'h0;
    logic        avs_waitrequest_out, tx_valid_out, tx_first_out, tx_last_out, tx_ready_in;
    logic [7:0]  exp_q[$], pk[$], last_p[$], last_s[$];
    logic [2:0]  ctrl_m = 3'h0;
    int          fails = 0, tests_run = 0, hr_m = 23, mn_m = 59, sc_m = 58;
    gtrf_framer #(.START_CYCLES(200)) dut (.*);
    gtrf_sink u_sink (.clk_in(clk_in), .slow_in(slow), .data_in(tx_data_out),
        .valid_in(tx_valid_out), .first_in(tx_first_out), .last_in(tx_last_out),
        .ready_out(tx_ready_in));
    // Clock and watchdog
    always #10 clk_in = ~clk_in;
    initial begin
        #1_000_000;
        fails++;
        results();
    end
    function automatic logic [31:0] rand32();
        rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
        rand32[31:16] = rnd;
        rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
        rand32[15:0] = rnd;
    endfunction
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // One bus access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
        int k;
        k = 0;
        avs_address_in <= a;
        avs_writedata_in <= v;
        avs_write_in <= w;
        avs_read_in <= !w;
        @(posedge clk_in);
        while (avs_waitrequest_out !== 1'b0 && k < 50) begin
            @(posedge clk_in);
            k++;
        end
        if (k == 50) fails++;
        rd_q = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic setctrl(input logic [2:0] v);
        ctrl_m = v;
        bus(1'b1, gtrf_pkg::ADDR_CTRL, {29'h0, v});
    endtask
    task automatic shuffle();
        sow_in <= 20'(rand32() % 604800);
        leap_offset_in <= 16'(rand32() % 64 + 1);
        day_in <= 5'(rand32() % 31 + 1);
        month_in <= 4'(rand32() % 12 + 1);
        year_in <= 16'(rand32() % 100 + 1980);
        survey_progress_in <= 8'(rand32() % 101);
        pos_avg_in <= {rand32(), rand32(), rand32()};
        pos_hold_in <= {rand32(), rand32(), rand32()};
        pos_fix_in <= {rand32(), rand32(), rand32()};
    endtask
    // Timing pulse; the model clock of day steps once per second
    task automatic pulse();
        pps_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        pps_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        if (sc_m == 59 && mn_m == 59 && hr_m == 23 && leap_insert_in && ctrl_m[2] && leap_known_in)
            sc_m = 60;
        else if (sc_m < 59)
            sc_m++;
        else begin
            sc_m = 0;
            mn_m = (mn_m + 1) % 60;
            if (mn_m == 0) hr_m = (hr_m + 1) % 24;
        end
    endtask
    task automatic put(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) pk.push_back(v[8*i +: 8]);
    endtask
    // Expected report bytes, built from the inputs seen at the pulse
    task automatic push_prim();
        logic [15:0] w;
        w = {6'h0, week_raw_in};
        if (week_raw_in < 10'd1023) w = w + 16'd1024;
        pk.delete();
        pk.push_back(gtrf_pkg::SUB_PRIM);
        put({12'h0, sow_in}, 4);
        put({16'h0, w}, 2);
        put(leap_known_in ? {16'h0, leap_offset_in} : 32'h0, 2);
        pk.push_back({4'h0, !leap_known_in, !time_set_in, 1'b0, ctrl_m[2] & leap_known_in});
        put({sc_m[7:0], mn_m[7:0], hr_m[7:0], 3'h0, day_in}, 4);
        put({12'h0, month_in, year_in}, 3);
        last_p = pk;
        exp_q = {exp_q, pk};
    endtask
    task automatic push_supp();
        logic [95:0] p;
        p = survey_active_in ? pos_avg_in : (rx_mode_in inside {1, 6, 7}) ? pos_hold_in
            : pos_fix_in;
        pk.delete();
        pk.push_back(gtrf_pkg::SUB_SUPP);
        put({rx_mode_in, 8'h00, survey_progress_in}, 3);
        put(p[95:64], 4);
        put(p[63:32], 4);
        put(p[31:0], 4);
        last_s = pk;
        exp_q = {exp_q, pk};
    endtask
    // Wait for the sink, then compare every byte and the total count
    task automatic drain(input string n);
        int k = 0, np = 0;
        while (u_sink.rx_q.size() < exp_q.size() && k < 3000) begin
            @(posedge clk_in);
            k++;
        end
        repeat (40) @(posedge clk_in);
        chk({n, " length"}, exp_q.size(), u_sink.rx_q.size());
        foreach (exp_q[i]) if (i < u_sink.rx_q.size()) chk(n, exp_q[i], u_sink.rx_q[i]);
        for (int i = 0; i < exp_q.size(); np++)
            i += (exp_q[i] == 8'hAB) ? 17 : (exp_q[i] == 8'hAC) ? 16 : 4;
        chk({n, " framing"}, 2 * np, u_sink.pkts);
        u_sink.pkts = 0;
        exp_q.delete();
        u_sink.rx_q.delete();
        $display("test %s done", n);
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        chk("tx_valid", 32'h0, {31'h0, tx_valid_out});
        bus(1'b0, gtrf_pkg::ADDR_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, rd_q);
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped", 32'h0, rd_q);
        bus(1'b0, gtrf_pkg::ADDR_STATUS, 32'h0);
        chk("idle state", 32'h1, {28'h0, rd_q[11:8]});
        shuffle();
        week_raw_in <= 10'(rand32());
        tod_load_in <= 1'b1;
        @(posedge clk_in);
        tod_load_in <= 1'b0;
        setctrl(3'h3);
        pulse();
        push_prim();
        push_supp();
        drain("auto satellite scale");
        leap_known_in <= 1'b1;
        time_set_in <= 1'b1;
        leap_insert_in <= 1'b1;
        survey_active_in <= 1'b0;
        slow <= 1'b1;
        setctrl(3'h7);
        for (int i = 0; i < 4; i++) begin
            rx_mode_in <= (i == 0) ? 8'h07 : (i == 1) ? 8'h04 : (i == 2) ? 8'h01 : 8'h06;
            week_raw_in <= 10'(1021 + i);
            @(posedge clk_in);
            pulse();
            push_prim();
            push_supp();
            shuffle();
            drain("auto utc leap");
        end
        setctrl(3'h0);
        exp_q = {last_p, last_s};
        bus(1'b1, gtrf_pkg::ADDR_REQ, 32'h3);
        drain("requests");
        for (int i = 0; i < 4; i++) begin
            d = rand32();
            d[31:24] = (i == 0) ? 8'hA5 : (i == 1) ? 8'hA6 : (i == 2) ? 8'hA9 : 8'h55;
            if (i == 0) d[9:8] = 2'b01;
            pk.delete();
            if (i < 3) put(d, 4);
            exp_q = pk;
            bus(1'b1, gtrf_pkg::ADDR_ECHO, d);
            drain("echo");
        end
        bus(1'b0, gtrf_pkg::ADDR_CTRL, 32'h0);
        chk("ctrl after mask echo", 32'h1, rd_q);
        ctrl_m = 3'h1;
        pulse();
        push_prim();
        drain("primary only");
        results();
    end
    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
endmodule
`default_nettype wire
